// ### logic/pcfg_pkg.sv
// pcfg_pkg: constants and carrier types of the config header bank
// assumes: one pci clock domain and two host-controller functions
package pcfg_pkg;
    // function numbers of the two host controllers
    localparam int         NFUNC   = 2;
    localparam logic [0:0] FUNC_FS = 1'h0;
    localparam logic [0:0] FUNC_HS = 1'h1;

    // byte offsets inside the configuration header
    localparam logic [7:0] OFS_MAKER = 8'h00;
    localparam logic [7:0] OFS_PART  = 8'h02;
    localparam logic [7:0] OFS_CMD   = 8'h04;

    // dword indexes derived from the byte offsets
    localparam logic [5:0] DW_ID  = OFS_MAKER[7:2];
    localparam logic [5:0] DW_CMD = OFS_CMD[7:2];

    // command field positions
    localparam int CMD_IO   = 0;
    localparam int CMD_MEM  = 1;
    localparam int CMD_BM   = 2;
    localparam int CMD_SPC  = 3;
    localparam int CMD_MWI  = 4;
    localparam int CMD_SNP  = 5;
    localparam int CMD_PER  = 6;
    localparam int CMD_STEP = 7;
    localparam int CMD_SERR = 8;
    localparam int CMD_FBB  = 9;

    // reset value and the bits that software may change
    localparam logic [15:0] CMD_RESET   = 16'h0000;
    localparam logic [15:0] CMD_WR_MASK = 16'h0357;

    // identification words, values arbitrary
    localparam logic [15:0] MAKER_DEF   = 16'h5a5a;
    localparam logic [15:0] PART_FS_DEF = 16'h0a01;
    localparam logic [15:0] PART_HS_DEF = 16'h0a02;

    localparam logic [15:0] HALF_ZERO = 16'h0000;
    localparam logic [31:0] RD_ZERO   = 32'h0000_0000;

    // one configuration access as the pci core hands it over
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [0:0] func;
        logic [5:0] dword;
        logic [3:0] be;
        logic [31:0] wdata;
    } pcfg_req_s;

    // answer state of the configuration port
    typedef enum logic [0:0] {
        CS_IDLE = 1'b0,
        CS_ACK  = 1'b1
    } pcfg_cstate_e;
endpackage

// ### logic/pcfg_cmd_reg.sv
// pcfg_cmd_reg: one function's command register
// assumes: write strobe already decoded for this function and offset
`timescale 1ns/1ps
module pcfg_cmd_reg (
    input  wire logic        core_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        wr_i,
    input  wire logic [1:0]  be_i,
    input  wire logic [15:0] wdata_i,
    output logic      [15:0] cmd_o
);
    logic [15:0] lane_mask;
    logic [15:0] next_cmd;

    // read-only bits never move, so they read back zero
    assign lane_mask = {{8{be_i[1]}}, {8{be_i[0]}}}
                     & pcfg_pkg::CMD_WR_MASK;
    assign next_cmd  = wr_i ? ((cmd_o & ~lane_mask) | (wdata_i & lane_mask))
                            : cmd_o;

    // whole register clears on reset
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cmd_o <= pcfg_pkg::CMD_RESET;
        end else begin
            cmd_o <= next_cmd;
        end
    end
endmodule

// ### logic/pcfg_err_gate.sv
// pcfg_err_gate: parity error reporting of one function
// assumes: error strobes are one-cycle pulses from the pci core
`timescale 1ns/1ps
module pcfg_err_gate (
    input  wire logic        core_clk_i,
    input  wire logic        nrst_i,
    input  wire logic [15:0] cmd_i,
    input  wire logic        addr_par_i,
    input  wire logic        data_par_i,
    input  wire logic        dpe_clr_i,
    output logic             serr_drv_o,
    output logic             perr_drv_o,
    output logic             dpe_o
);
    logic next_serr;
    logic next_perr;
    logic next_dpe;

    // system error needs both enables; parity pin needs response enable
    assign next_serr = addr_par_i & cmd_i[pcfg_pkg::CMD_SERR]
                     & cmd_i[pcfg_pkg::CMD_PER];
    assign next_perr = data_par_i & cmd_i[pcfg_pkg::CMD_PER];
    // status flag sets regardless of enables; a set beats a clear
    assign next_dpe  = addr_par_i | data_par_i
                     | (dpe_o & ~dpe_clr_i);

    // drivers held one cycle each, as the pins want
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            serr_drv_o <= 1'b0;
            perr_drv_o <= 1'b0;
            dpe_o      <= 1'b0;
        end else begin
            serr_drv_o <= next_serr;
            perr_drv_o <= next_perr;
            dpe_o      <= next_dpe;
        end
    end
endmodule

// ### logic/pcfg_header_top.sv
// pcfg_header_top: id words and command registers of both functions,
// plus the gating that the command bits impose on the pci core
// assumes: all inputs except the two sensed pins are on core_clk_i
`timescale 1ns/1ps
// How it works
// - Offset zero returns a fixed maker word and writes to it are dropped.
// - Offset two returns a fixed part word that differs per function.
// - Offset four is a 16-bit command register that resets to zero.
// - An all-zero command leaves only configuration accesses answered.
// - Fast back-to-back to other agents only while that enable is set.
// - The system error pin is driven only while its enable is one.
// - Address parity errors are reported only with both enables set.
// - The stepping bit is read-only zero.
// - The high-speed function differs from the other only in part word.
// - Without parity response the flag still sets but the pin stays off.
// - Write-and-invalidate only when its enable is one, else plain write.
// - Special cycles are ignored while the monitor bit is zero.
// - No master access starts while the bus master bit is zero.
module pcfg_header_top #(
    parameter int          NF      = pcfg_pkg::NFUNC,
    parameter logic [15:0] MAKER   = pcfg_pkg::MAKER_DEF,
    parameter logic [15:0] PART_FS = pcfg_pkg::PART_FS_DEF,
    parameter logic [15:0] PART_HS = pcfg_pkg::PART_HS_DEF
) (
    input  wire logic                core_clk_i,
    input  wire logic                nrst_i,
    input  wire pcfg_pkg::pcfg_req_s cfg_req_i,
    output logic                     cfg_ready_o,
    output logic                     cfg_ack_o,
    output logic [31:0]              cfg_rdata_o,
    input  wire logic [NF-1:0]       mem_hit_i,
    input  wire logic [NF-1:0]       io_hit_i,
    output logic [NF-1:0]            mem_claim_o,
    output logic [NF-1:0]            io_claim_o,
    output logic [NF-1:0]            disconn_o,
    input  wire logic [NF-1:0]       mst_req_i,
    input  wire logic [NF-1:0]       mst_mwi_i,
    input  wire logic [NF-1:0]       mst_fbb_i,
    output logic [NF-1:0]            mst_req_o,
    output logic [NF-1:0]            mst_mwi_o,
    output logic [NF-1:0]            mst_fbb_o,
    input  wire logic                spc_cycle_i,
    output logic [NF-1:0]            spc_take_o,
    input  wire logic [NF-1:0]       addr_par_i,
    input  wire logic [NF-1:0]       data_par_i,
    input  wire logic [NF-1:0]       dpe_clr_i,
    output logic [NF-1:0]            dpe_o,
    input  wire logic                serr_n_i,
    output logic                     serr_n_o,
    output logic                     serr_oe_o,
    input  wire logic                perr_n_i,
    output logic                     perr_n_o,
    output logic                     perr_oe_o,
    output logic                     serr_seen_o,
    output logic                     perr_seen_o
);
    // per-function command words and error drivers
    logic [NF-1:0][15:0] cmd_all;
    logic [NF-1:0]       cmd_wr;
    logic [NF-1:0]       serr_drv;
    logic [NF-1:0]       perr_drv;

    // configuration port state
    pcfg_pkg::pcfg_cstate_e cstate;
    pcfg_pkg::pcfg_cstate_e next_cstate;
    logic                   req_take;
    logic                   wr_take;
    logic [15:0]            part_sel;
    logic [15:0]            cmd_sel;
    logic [31:0]            next_rdata;

    // pin sense synchronisers, bit 0 system error, bit 1 parity
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;

    // read word of one function for one dword index
    function automatic logic [31:0] rd_word(input logic [5:0]  dw,
                                            input logic [15:0] part,
                                            input logic [15:0] cmd);
        logic [31:0] w;
        w = pcfg_pkg::RD_ZERO;
        case (dw)
            pcfg_pkg::DW_ID:  w = {part, MAKER};
            pcfg_pkg::DW_CMD: w = {pcfg_pkg::HALF_ZERO, cmd};
            default:          w = pcfg_pkg::RD_ZERO;
        endcase
        return w;
    endfunction

    // a function counts as detached while its command word is zero
    function automatic logic is_detached(input logic [15:0] cmd);
        return cmd == pcfg_pkg::CMD_RESET;
    endfunction

    // one request at a time; a new one waits for the answer cycle
    assign cfg_ready_o = (cstate == pcfg_pkg::CS_IDLE);
    assign req_take    = cfg_req_i.valid & cfg_ready_o;
    assign wr_take     = req_take & cfg_req_i.write;

    // only the high-speed function swaps its part word
    assign part_sel = (cfg_req_i.func == pcfg_pkg::FUNC_HS) ? PART_HS
                                                            : PART_FS;
    assign cmd_sel  = cmd_all[cfg_req_i.func];
    // id dword is read-only: writes there reach no storage
    assign next_rdata = cfg_req_i.write ? pcfg_pkg::RD_ZERO
                      : rd_word(cfg_req_i.dword, part_sel, cmd_sel);

    // answer state machine
    always_comb begin
        next_cstate = cstate;
        case (cstate)
            pcfg_pkg::CS_IDLE: begin
                if (req_take) begin
                    next_cstate = pcfg_pkg::CS_ACK;
                end
            end
            pcfg_pkg::CS_ACK: begin
                next_cstate = pcfg_pkg::CS_IDLE;
            end
            default: begin
                next_cstate = pcfg_pkg::CS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cstate <= pcfg_pkg::CS_IDLE;
        end else begin
            cstate <= next_cstate;
        end
    end

    // read data held until the next accepted request
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_rdata_o <= pcfg_pkg::RD_ZERO;
        end else if (req_take) begin
            cfg_rdata_o <= next_rdata;
        end
    end

    assign cfg_ack_o = (cstate == pcfg_pkg::CS_ACK);

    // one register copy and one error gate per function
    for (genvar f = 0; f < NF; f++) begin : g_fn
        assign cmd_wr[f] = wr_take & (cfg_req_i.dword == pcfg_pkg::DW_CMD)
                         & (cfg_req_i.func == 1'(f));

        pcfg_cmd_reg u_cmd (
            .core_clk_i (core_clk_i),
            .nrst_i     (nrst_i),
            .wr_i       (cmd_wr[f]),
            .be_i       (cfg_req_i.be[1:0]),
            .wdata_i    (cfg_req_i.wdata[15:0]),
            .cmd_o      (cmd_all[f])
        );

        pcfg_err_gate u_err (
            .core_clk_i (core_clk_i),
            .nrst_i     (nrst_i),
            .cmd_i      (cmd_all[f]),
            .addr_par_i (addr_par_i[f]),
            .data_par_i (data_par_i[f]),
            .dpe_clr_i  (dpe_clr_i[f]),
            .serr_drv_o (serr_drv[f]),
            .perr_drv_o (perr_drv[f]),
            .dpe_o      (dpe_o[f])
        );

        // target side: a zero word also forces every enable off
        assign disconn_o[f]   = is_detached(cmd_all[f]);
        assign mem_claim_o[f] = mem_hit_i[f] & ~disconn_o[f]
                              & cmd_all[f][pcfg_pkg::CMD_MEM];
        assign io_claim_o[f]  = io_hit_i[f] & ~disconn_o[f]
                              & cmd_all[f][pcfg_pkg::CMD_IO];
        assign spc_take_o[f]  = spc_cycle_i & ~disconn_o[f]
                              & cmd_all[f][pcfg_pkg::CMD_SPC];

        // master side: nothing leaves without bus master enable
        assign mst_req_o[f] = mst_req_i[f]
                            & cmd_all[f][pcfg_pkg::CMD_BM];
        assign mst_mwi_o[f] = mst_req_o[f] & mst_mwi_i[f]
                            & cmd_all[f][pcfg_pkg::CMD_MWI];
        assign mst_fbb_o[f] = mst_req_o[f] & mst_fbb_i[f]
                            & cmd_all[f][pcfg_pkg::CMD_FBB];
    end

    // shared open-drain pins: pull low while any function drives
    assign serr_n_o  = 1'b0;
    assign perr_n_o  = 1'b0;
    assign serr_oe_o = |serr_drv;
    assign perr_oe_o = |perr_drv;

    // the wired pins come from outside, so sense them through two synchroniser stages and an output register
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_s1      <= 2'h3;
            pin_s2      <= 2'h3;
            serr_seen_o <= 1'b0;
            perr_seen_o <= 1'b0;
        end else begin
            pin_s1      <= {perr_n_i, serr_n_i};
            pin_s2      <= pin_s1;
            serr_seen_o <= ~pin_s2[0];
            perr_seen_o <= ~pin_s2[1];
        end
    end

    // checking helpers
    logic rst_seen;
    logic serr_cause;
    logic perr_cause;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_seen <= 1'b0;
        end else begin
            rst_seen <= 1'b1;
        end
    end

    always_comb begin
        serr_cause = 1'b0;
        perr_cause = 1'b0;
        for (int i = 0; i < NF; i++) begin
            serr_cause = serr_cause | (addr_par_i[i]
                       & cmd_all[i][pcfg_pkg::CMD_SERR]
                       & cmd_all[i][pcfg_pkg::CMD_PER]);
            perr_cause = perr_cause | (data_par_i[i]
                       & cmd_all[i][pcfg_pkg::CMD_PER]);
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_id_read;
        req_take && !cfg_req_i.write
        && cfg_req_i.dword == pcfg_pkg::DW_ID;
    endsequence

    sequence s_answer;
        cfg_ack_o && !cfg_ready_o;
    endsequence

    property p_maker_read;
        s_id_read |=> s_answer and cfg_rdata_o[15:0] == MAKER;
    endproperty
    a_maker_read: assert property (p_maker_read)
        else $error("maker word read back wrong");

    property p_part_read;
        s_id_read ##0 (cfg_req_i.func == pcfg_pkg::FUNC_HS)
        |=> cfg_rdata_o[31:16] == PART_HS;
    endproperty
    a_part_read: assert property (p_part_read)
        else $error("high-speed part word wrong");

    property p_cmd_reset;
        !rst_seen |-> cmd_all == '0;
    endproperty
    a_cmd_reset: assert property (p_cmd_reset)
        else $error("command word not zero after reset");

    property p_detached;
        disconn_o[0] |-> !mem_claim_o[0] && !io_claim_o[0]
                         && !mst_req_o[0] && !spc_take_o[0];
    endproperty
    a_detached: assert property (p_detached)
        else $error("zero command word still acts on bus");

    property p_fbb;
        mst_fbb_o[1] |-> cmd_all[1][pcfg_pkg::CMD_FBB] && mst_req_i[1];
    endproperty
    a_fbb: assert property (p_fbb)
        else $error("fast back-to-back without enable");

    property p_serr_only_enabled;
        serr_oe_o |-> $past(serr_cause);
    endproperty
    a_serr_only_enabled: assert property (p_serr_only_enabled)
        else $error("system error pin driven without cause");

    property p_addr_par_report;
        serr_cause |=> serr_oe_o ##1 !serr_oe_o || $past(serr_cause);
    endproperty
    a_addr_par_report: assert property (p_addr_par_report)
        else $error("address parity error not reported");

    property p_step_zero;
        req_take && !cfg_req_i.write
        && cfg_req_i.dword == pcfg_pkg::DW_CMD
        |=> !cfg_rdata_o[pcfg_pkg::CMD_STEP]
            && !cfg_rdata_o[pcfg_pkg::CMD_SNP];
    endproperty
    a_step_zero: assert property (p_step_zero)
        else $error("stepping or snoop bit reads one");

    property p_perr_gate;
        perr_oe_o |-> $past(perr_cause);
    endproperty
    a_perr_gate: assert property (p_perr_gate)
        else $error("parity pin driven without response enable");

    property p_dpe_set;
        data_par_i[0] |=> dpe_o[0] [*2] or (dpe_o[0] ##1 $past(dpe_clr_i[0]));
    endproperty
    a_dpe_set: assert property (p_dpe_set)
        else $error("detected parity flag not set");

    property p_mwi;
        mst_mwi_o[0] |-> mst_req_o[0] && cmd_all[0][pcfg_pkg::CMD_MWI];
    endproperty
    a_mwi: assert property (p_mwi)
        else $error("write-and-invalidate without enable");

    property p_spc;
        !cmd_all[0][pcfg_pkg::CMD_SPC] |-> !spc_take_o[0];
    endproperty
    a_spc: assert property (p_spc)
        else $error("special cycle taken while ignored");

    property p_bm;
        mst_req_o != '0 |-> (mst_req_o & ~mst_req_i) == '0
                        && cmd_all[0][pcfg_pkg::CMD_BM] | !mst_req_o[0];
    endproperty
    a_bm: assert property (p_bm)
        else $error("master access without bus master enable");

    property p_fn_indep;
        cmd_wr[0] |=> $stable(cmd_all[1]);
    endproperty
    a_fn_indep: assert property (p_fn_indep)
        else $error("write to one function changed the other");

    property p_mem_claim;
        mem_claim_o[1] |-> cmd_all[1][pcfg_pkg::CMD_MEM] && mem_hit_i[1];
    endproperty
    a_mem_claim: assert property (p_mem_claim)
        else $error("memory claim without space enable");
endmodule

// ### dv/pcfg_host_model.sv
// pcfg_host_model: host bridge issuing configuration cycles
// assumes: same clock as the header bank, driven 1 ns after each edge
`timescale 1ns/1ps
module pcfg_host_model #(
    parameter bit ALL_FBB = 1'b1  // every target on the bus is b2b capable
) (
    input  wire logic                core_clk_i,
    input  wire logic                cfg_ready_i,
    input  wire logic                cfg_ack_i,
    input  wire logic [31:0]         cfg_rdata_i,
    output pcfg_pkg::pcfg_req_s      cfg_req_o
);
    initial cfg_req_o = '0;

    // one configuration cycle; request held until the taking edge
    task automatic cfg_xfer(input  logic        wr,
                            input  logic [0:0]  fn,
                            input  logic [5:0]  dw,
                            input  logic [3:0]  be,
                            input  logic [31:0] wd,
                            output logic [31:0] rd,
                            output logic        ok);
        int i;
        ok = 1'b0;
        @(posedge core_clk_i);
        #1;
        if (dw == pcfg_pkg::DW_CMD) begin
            wd[15:10] = 6'h00;
            if (!ALL_FBB) begin
                wd[9] = 1'b0;
            end
        end
        cfg_req_o = '{1'b1, wr, fn, dw, be, wd};
        // bounded wait; ready is settled 1 ns after the edge
        for (i = 0; i < 16 && !ok; i++) begin
            if (cfg_ready_i === 1'b1) ok = 1'b1;
            @(posedge core_clk_i);
            #1;
        end
        // now in the answer cycle: take data, then let go
        ok = ok && (cfg_ack_i === 1'b1);
        rd = cfg_rdata_i;
        cfg_req_o.valid = 1'b0;
    endtask
endmodule

// ### dv/tb_pci_config_header_command.sv
// tb_pci_config_header_command: table-driven bench of the header bank
// assumes: pcfg_host_model as the only config initiator
`timescale 1ns/1ps
module tb_pci_config_header_command;
    typedef struct packed {
        logic [0:0]  func;
        logic [3:0]  be;
        logic [15:0] wdata;
        logic [15:0] exp;
    } pcfg_row_s;

    logic                core_clk_i = 1'b0;
    logic                nrst_i     = 1'b0;
    pcfg_pkg::pcfg_req_s cfg_req;
    logic                cfg_ready, cfg_ack;
    logic [31:0]         cfg_rdata, rd;
    logic [1:0]          mem_hit = '0, io_hit = '0, mst_req = '0;
    logic [1:0]          mst_mwi = '0, mst_fbb = '0;
    logic [1:0]          addr_par = '0, data_par = '0, dpe_clr = '0;
    logic                spc_cycle = 1'b0;
    logic [1:0]          mem_claim, io_claim, disconn, spc_take, detected_parity_error;
    logic [1:0]          mst_go, mwi_go, fbb_go;
    logic                serr_n_drv, serr_oe, perr_n_drv, perr_oe;
    logic                serr_seen, perr_seen;
    logic                serr_hit = 1'b0, perr_hit = 1'b0;
    wire                 serr_pin, perr_pin;
    logic [15:0]         exp_cmd [2];
    pcfg_row_s           rows [8];
    int                  n_errors = 0, checked = 0, i;

    always #5 core_clk_i = ~core_clk_i;

    // pulled-up open-drain pins, low only while a driver is enabled
    assign serr_pin = serr_oe ? serr_n_drv : 1'b1;
    assign perr_pin = perr_oe ? perr_n_drv : 1'b1;

    // remember that the sensed pins ever came back low
    always @(posedge core_clk_i) begin
        if (serr_seen === 1'b1) serr_hit <= 1'b1;
        if (perr_seen === 1'b1) perr_hit <= 1'b1;
    end

    pcfg_host_model host (
        .core_clk_i  (core_clk_i),
        .cfg_ready_i (cfg_ready),
        .cfg_ack_i   (cfg_ack),
        .cfg_rdata_i (cfg_rdata),
        .cfg_req_o   (cfg_req)
    );

    pcfg_header_top dut (
        .core_clk_i  (core_clk_i),
        .nrst_i      (nrst_i),
        .cfg_req_i   (cfg_req),
        .cfg_ready_o (cfg_ready),
        .cfg_ack_o   (cfg_ack),
        .cfg_rdata_o (cfg_rdata),
        .mem_hit_i   (mem_hit),
        .io_hit_i    (io_hit),
        .mem_claim_o (mem_claim),
        .io_claim_o  (io_claim),
        .disconn_o   (disconn),
        .mst_req_i   (mst_req),
        .mst_mwi_i   (mst_mwi),
        .mst_fbb_i   (mst_fbb),
        .mst_req_o   (mst_go),
        .mst_mwi_o   (mwi_go),
        .mst_fbb_o   (fbb_go),
        .spc_cycle_i (spc_cycle),
        .spc_take_o  (spc_take),
        .addr_par_i  (addr_par),
        .data_par_i  (data_par),
        .dpe_clr_i   (dpe_clr),
        .dpe_o       (detected_parity_error),
        .serr_n_i    (serr_pin),
        .serr_n_o    (serr_n_drv),
        .serr_oe_o   (serr_oe),
        .perr_n_i    (perr_pin),
        .perr_n_o    (perr_n_drv),
        .perr_oe_o   (perr_oe),
        .serr_seen_o (serr_seen),
        .perr_seen_o (perr_seen)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // a missing answer ends the run at once
    task automatic xfer(input logic w, input logic [0:0] f,
                        input logic [5:0] dw, input logic [3:0] be,
                        input logic [31:0] wd);
        logic ok;
        host.cfg_xfer(w, f, dw, be, wd, rd, ok);
        check(32'(ok), 32'h0000_0001);
        if (ok !== 1'b1) begin
            results();
        end
    endtask

    // all requests raised (or dropped), outputs follow the command words
    task automatic gate_chk(input logic h);
        logic [15:0] c;
        logic        nz;
        int          f;
        mem_hit   = {2{h}};
        io_hit    = {2{h}};
        mst_req   = {2{h}};
        mst_mwi   = {2{h}};
        mst_fbb   = {2{h}};
        spc_cycle = h;
        #1;
        for (f = 0; f < 2; f++) begin
            c  = exp_cmd[f];
            nz = (c != 16'h0000);
            check(32'({mem_claim[f], io_claim[f], disconn[f], spc_take[f]}),
                  32'({h & c[1] & nz, h & c[0] & nz, !nz, 1'b0}));
            check(32'({mst_go[f], mwi_go[f], fbb_go[f]}),
                  32'({h & c[2], h & c[2] & c[4], h & c[2] & c[9]}));
        end
    endtask

    // one-cycle parity strobes, drivers looked at in the next cycle
    task automatic par(input logic [1:0] a, input logic [1:0] d,
                       input logic es, input logic ep);
        @(posedge core_clk_i);
        #1;
        addr_par = a;
        data_par = d;
        @(posedge core_clk_i);
        #1;
        addr_par = 2'b00;
        data_par = 2'b00;
        check(32'({serr_oe, perr_oe}), 32'({es, ep}));
    endtask

    task automatic reset_dut();
        nrst_i     = 1'b0;
        exp_cmd[0] = 16'h0000;
        exp_cmd[1] = 16'h0000;
        repeat (5) @(posedge core_clk_i);
        check(32'({cfg_ready, cfg_ack, disconn, detected_parity_error, serr_oe, perr_oe}),
              32'h0000_00b0);
        #1;
        nrst_i = 1'b1;
    endtask

    initial begin
        rows = '{'{1'h0, 4'hf, 16'hffff, 16'h0357},
                 '{1'h1, 4'hf, 16'h0001, 16'h0001},
                 '{1'h0, 4'h1, 16'h0000, 16'h0300},
                 '{1'h0, 4'h2, 16'h0000, 16'h0000},
                 '{1'h1, 4'hf, 16'h0014, 16'h0014},
                 '{1'h1, 4'h3, 16'h0216, 16'h0216},
                 '{1'h0, 4'hf, 16'h00a8, 16'h0000},
                 '{1'h0, 4'hf, 16'h0006, 16'h0006}};
        reset_dut();
        // parity while disconnected: flags only, no pin drive
        par(2'b01, 2'b01, 1'b0, 1'b0);
        check(32'(detected_parity_error), 32'h0000_0001);
        // id words ignore writes and differ per function
        for (i = 0; i < 2; i++) begin
            xfer(1'b1, 1'(i), pcfg_pkg::DW_ID, 4'hf, 32'hffff_ffff);
            xfer(1'b0, 1'(i), pcfg_pkg::DW_ID, 4'hf, 32'h0000_0000);
            check(rd, {(i == 1) ? pcfg_pkg::PART_HS_DEF : pcfg_pkg::PART_FS_DEF,
                       pcfg_pkg::MAKER_DEF});
        end
        xfer(1'b0, 1'h0, 6'h05, 4'hf, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        // command rows, each function kept apart
        for (i = 0; i < 8; i++) begin
            xfer(1'b1, rows[i].func, pcfg_pkg::DW_CMD, rows[i].be,
                 {16'hffff, rows[i].wdata});
            exp_cmd[rows[i].func] = rows[i].exp;
            xfer(1'b0, rows[i].func, pcfg_pkg::DW_CMD, 4'hf, 32'h0000_0000);
            check(rd, {16'h0000, rows[i].exp});
            gate_chk(1'b1);
        end
        gate_chk(1'b0);
        // no pin may have been pulled low while both words were zero
        check(32'({serr_hit, perr_hit}), 32'h0000_0000);
        // error reporting with both enables, and serr without parity
        xfer(1'b1, 1'h0, pcfg_pkg::DW_CMD, 4'hf, 32'h0000_0140);
        xfer(1'b1, 1'h1, pcfg_pkg::DW_CMD, 4'hf, 32'h0000_0100);
        dpe_clr = 2'b11;
        @(posedge core_clk_i);
        #1;
        dpe_clr = 2'b00;
        par(2'b01, 2'b00, 1'b1, 1'b0);
        par(2'b10, 2'b00, 1'b0, 1'b0);
        par(2'b00, 2'b01, 1'b0, 1'b1);
        par(2'b00, 2'b10, 1'b0, 1'b0);
        check(32'(detected_parity_error), 32'h0000_0003);
        dpe_clr = 2'b11;
        @(posedge core_clk_i);
        #1;
        dpe_clr = 2'b00;
        check(32'(detected_parity_error), 32'h0000_0000);
        // set and clear in one cycle: the set wins
        data_par = 2'b01;
        dpe_clr  = 2'b01;
        @(posedge core_clk_i);
        #1;
        data_par = 2'b00;
        dpe_clr  = 2'b00;
        check(32'(detected_parity_error), 32'h0000_0001);
        repeat (4) @(posedge core_clk_i);
        #1;
        check(32'({serr_hit, perr_hit}), 32'h0000_0003);
        // reset in mid-run brings both command words back to zero
        reset_dut();
        for (i = 0; i < 2; i++) begin
            xfer(1'b0, 1'(i), pcfg_pkg::DW_CMD, 4'hf, 32'h0000_0000);
            check(rd, 32'h0000_0000);
        end
        gate_chk(1'b1);
        results();
    end
endmodule
